/* core/hstc_pkg.sv */
// Constants, codes and register layouts for the switch and timer B block.
// Assumes a 50 MHz system clock and byte registers on a serial port.
package hstc_pkg;

  // Clock and timer step
  localparam int CLK_NS = 20;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = (TICK_US * 1000 + CLK_NS - 1) / CLK_NS;

  // On-time in us and period in ms, indexed by field code
  localparam int ON_US [8] = '{0, 100, 300, 1000, 10000, 20000, 0, 0};
  localparam int PER_MS [8] = '{10, 20, 50, 100, 200, 1000, 2000, 0};

  // Register addresses
  localparam logic [6:0] ADDR_TMR_B = 7'h0D;
  localparam logic [6:0] ADDR_SD = 7'h10;
  localparam logic [6:0] ADDR_SEL_A = 7'h14;
  localparam logic [6:0] ADDR_SEL_B = 7'h15;

  // Reset values and writable-bit masks
  localparam logic [7:0] RST_TMR_B = 8'h00;
  localparam logic [7:0] RST_SD = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] MASK_TMR_B = 8'h77;
  localparam logic [7:0] MASK_SD = 8'h70;
  localparam logic [7:0] MASK_SEL = 8'h77;
  localparam logic [7:0] RESTART_KEEP_SD = 8'h70;

  // Serial frame: 7 address bits, write flag, 8 data bits
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h08;

  typedef enum logic [2:0] {
    ON_LOW, ON_0P1, ON_0P3, ON_1P0, ON_10, ON_20, ON_HIGH, ON_RSV
  } hstc_on_t;

  typedef enum logic [2:0] {
    SEL_OFF, SEL_ON, SEL_TMR_A, SEL_TMR_B, SEL_PWM_A, SEL_PWM_B,
    SEL_RSV6, SEL_RSV7
  } hstc_sel_t;

  typedef struct packed {
    logic rsv_hi;
    hstc_on_t on_time;
    logic rsv_lo;
    logic [2:0] period;
  } hstc_tmr_t;

  typedef struct packed {
    logic rsv_hi;
    logic ov_inhibit;
    logic uv_inhibit;
    logic recovery;
    logic [3:0] rsv_lo;
  } hstc_sd_t;

  typedef struct packed {
    logic rsv_hi;
    hstc_sel_t hi;
    logic rsv_lo;
    hstc_sel_t lo;
  } hstc_pair_t;

  // Code to count of timer steps
  function automatic logic [14:0] on_ticks(input logic [2:0] code);
    return 15'(ON_US[code] / TICK_US);
  endfunction : on_ticks

  function automatic logic [14:0] per_ticks(input logic [2:0] code);
    return 15'(PER_MS[code] * 1000 / TICK_US);
  endfunction : per_ticks

endpackage : hstc_pkg

/* core/hstc_timer_b.sv */
// Timer B: periodic on-pulse from coded period and on-time.
// Assumes its configuration comes from a register on the same clock.
`timescale 1ns/1ns
module hstc_timer_b #(
  parameter int TICK_CYC = hstc_pkg::TICK_CYC
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire hstc_pkg::hstc_tmr_t cfg_in,
  output logic level_out
);
  localparam int PW = $clog2(TICK_CYC + 1);

  hstc_pkg::hstc_tmr_t cfg_q;
  logic [PW-1:0] pre_q;
  logic [14:0] cnt_q;
  logic [14:0] cnt_d;
  logic run;
  logic chg;
  logic tick;
  logic last;

  // Running only on a timed code and a valid period
  assign run = (cfg_in.on_time inside {hstc_pkg::ON_0P1, hstc_pkg::ON_0P3,
    hstc_pkg::ON_1P0, hstc_pkg::ON_10, hstc_pkg::ON_20})
    && (cfg_in.period != 3'h7);
  assign chg = (cfg_in != cfg_q);
  assign tick = (pre_q == PW'(TICK_CYC - 1));
  assign last = (cnt_q == hstc_pkg::per_ticks(cfg_in.period) - 15'h1);

  // Previous setting, to restart on a new code
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cfg_q <= hstc_pkg::hstc_tmr_t'(hstc_pkg::RST_TMR_B);
    end else begin
      cfg_q <= cfg_in;
    end
  end

  // 0.1 ms step prescaler
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !run || chg || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  // Period count, wraps at the period boundary
  always_comb begin
    cnt_d = cnt_q;
    if (!run || chg) begin
      cnt_d = 15'h0;
    end else if (tick) begin
      cnt_d = last ? 15'h0 : cnt_q + 15'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cnt_q <= 15'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // High for the on-time from each period start
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      level_out <= 1'b0;
    end else if (cfg_in.on_time == hstc_pkg::ON_HIGH) begin
      level_out <= 1'b1;
    end else begin
      level_out <= run &&
        (cnt_d < hstc_pkg::on_ticks(cfg_in.on_time));
    end
  end

  a_tmr_low_off: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    cfg_in.on_time == hstc_pkg::ON_LOW |=> !level_out)
    else $error("timer B high while on-time is off-low");

  a_tmr_high_hold: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    cfg_in.on_time == hstc_pkg::ON_HIGH |=> level_out)
    else $error("timer B low while on-time is off-high");

  a_tmr_rsv_code: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    cfg_in.on_time == hstc_pkg::ON_RSV |=> !level_out && cnt_q == 15'h0)
    else $error("timer B ran on reserved on-time");

  a_tmr_auto_start: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    run && chg |=> level_out && cnt_q == 15'h0)
    else $error("timer B did not start on new code");

  a_tmr_period_wrap: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    run && !chg && tick && last ##1 !chg |-> cnt_q == 15'h0 && level_out)
    else $error("timer B did not restart its period");

endmodule : hstc_timer_b

/* core/hstc_top.sv */
// Switch source select, shutdown policy and timer B with register port.
// Assumes serial port pins and supply/switch faults are asynchronous;
// timer A, PWM sources, restart and soft reset come from this clock.
`timescale 1ns/1ns
module hstc_top #(
  parameter int TICK_CYC = hstc_pkg::TICK_CYC
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic soft_rst_in,
  input wire logic restart_mode_in,
  input wire logic cyclic_sense_in,
  input wire logic spi_csn_in,
  input wire logic spi_sck_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  input wire logic supply_ov_in,
  input wire logic supply_uv_in,
  input wire logic [3:0] switch_fault_in,
  input wire logic timer_a_in,
  input wire logic pwm_source_a_in,
  input wire logic pwm_source_b_in,
  output logic [3:0] switch_output_out,
  output logic timer_b_out
);
  localparam int NSYNC = 9;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic csn_s;
  logic sck_s;
  logic sdi_s;
  logic ov_s;
  logic uv_s;
  logic [3:0] fault_s;

  logic csn_prev_q;
  logic sck_prev_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0] sdo_q;
  logic sck_rise;
  logic sck_fall;
  logic wr;
  logic [6:0] wa;
  logic [7:0] wd;
  logic [7:0] rd_data;

  hstc_pkg::hstc_tmr_t tmr_q;
  hstc_pkg::hstc_sd_t sd_q;
  hstc_pkg::hstc_pair_t pair_q [2];
  logic rs_prev_q;
  logic rs_entry;
  logic clr;
  logic fault_now;
  logic fault_q;
  logic rec_clr;
  logic hw_clr;
  logic tmr_level;

  // Pins that cross into this clock
  assign async_in = {switch_fault_in, supply_uv_in, supply_ov_in,
    spi_sdi_in, spi_sck_in, spi_csn_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          meta_q[gi] <= (gi == 0); // Select pin idles high
          sync_q[gi] <= (gi == 0);
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign csn_s = sync_q[0];
  assign sck_s = sync_q[1];
  assign sdi_s = sync_q[2];
  assign ov_s = sync_q[3];
  assign uv_s = sync_q[4];
  assign fault_s = sync_q[8:5];

  // Serial clock and select edges
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      csn_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      csn_prev_q <= csn_s;
      sck_prev_q <= sck_s;
    end
  end

  assign sck_rise = !csn_s && sck_s && !sck_prev_q;
  assign sck_fall = !csn_s && !sck_s && sck_prev_q;

  // Bits in LSB first: address, write flag, then data
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || csn_s) begin
      bit_cnt_q <= 5'h0;
      shift_q <= 16'h0000;
    end else if (sck_rise) begin
      shift_q <= {sdi_s, shift_q[15:1]};
      if (bit_cnt_q != 5'h1F) begin
        bit_cnt_q <= bit_cnt_q + 5'h1;
      end
    end
  end

  // Read data loaded after the command byte, shifted on falling edges
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || csn_s) begin
      sdo_q <= 8'h00;
    end else if (sck_fall) begin
      if (bit_cnt_q == hstc_pkg::CMD_BITS) begin
        sdo_q <= rd_data;
      end else begin
        sdo_q <= {1'b0, sdo_q[7:1]};
      end
    end
  end

  assign spi_sdo_out = sdo_q[0];

  // Write lands when select rises after exactly sixteen bits
  assign wr = csn_s && !csn_prev_q && shift_q[7] &&
    (bit_cnt_q == hstc_pkg::FRAME_BITS);
  assign wa = shift_q[6:0];
  assign wd = shift_q[15:8];

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    case (shift_q[14:8])
      hstc_pkg::ADDR_TMR_B: rd_data = tmr_q & hstc_pkg::MASK_TMR_B;
      hstc_pkg::ADDR_SD: rd_data = sd_q & hstc_pkg::MASK_SD;
      hstc_pkg::ADDR_SEL_A: rd_data = pair_q[0] & hstc_pkg::MASK_SEL;
      hstc_pkg::ADDR_SEL_B: rd_data = pair_q[1] & hstc_pkg::MASK_SEL;
      default: rd_data = 8'h00;
    endcase
  end

  // Restart entry edge and common clear
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rs_prev_q <= 1'b0;
    end else begin
      rs_prev_q <= restart_mode_in;
    end
  end

  assign rs_entry = restart_mode_in && !rs_prev_q;
  assign clr = sys_rst_in || soft_rst_in;

  // Supply fault unless inhibited
  assign fault_now = (ov_s && !sd_q.ov_inhibit) ||
    (uv_s && !sd_q.uv_inhibit);

  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_now;
    end
  end

  // Fault gone without recovery: selects drop to off
  assign rec_clr = fault_q && !fault_now && !sd_q.recovery;
  assign hw_clr = (|fault_s) || rec_clr;

  // Shutdown policy register
  always_ff @(posedge clk_sys_in) begin
    if (clr) begin
      sd_q <= hstc_pkg::hstc_sd_t'(hstc_pkg::RST_SD);
    end else if (rs_entry) begin
      sd_q <= hstc_pkg::hstc_sd_t'(
        sd_q & hstc_pkg::RESTART_KEEP_SD);
    end else if (wr && wa == hstc_pkg::ADDR_SD) begin
      sd_q <= hstc_pkg::hstc_sd_t'(wd & hstc_pkg::MASK_SD);
    end
  end

  // Timer B register
  always_ff @(posedge clk_sys_in) begin
    if (clr || rs_entry) begin
      tmr_q <= hstc_pkg::hstc_tmr_t'(hstc_pkg::RST_TMR_B);
    end else if (restart_mode_in && cyclic_sense_in && hw_clr) begin
      tmr_q <= hstc_pkg::hstc_tmr_t'(hstc_pkg::RST_TMR_B);
    end else if (wr && wa == hstc_pkg::ADDR_TMR_B) begin
      tmr_q <= hstc_pkg::hstc_tmr_t'(
        wd & hstc_pkg::MASK_TMR_B);
    end
  end

  // Select pairs; a switch fault wins over a same-cycle write
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pair
      logic [6:0] addr;
      assign addr = (gi == 0) ? hstc_pkg::ADDR_SEL_A : hstc_pkg::ADDR_SEL_B;
      always_ff @(posedge clk_sys_in) begin
        if (clr || rs_entry || rec_clr) begin
          pair_q[gi] <= hstc_pkg::hstc_pair_t'(hstc_pkg::RST_SEL);
        end else begin
          if (wr && wa == addr) begin
            pair_q[gi] <= hstc_pkg::hstc_pair_t'(
              wd & hstc_pkg::MASK_SEL);
          end
          if (fault_s[2*gi]) begin
            pair_q[gi].lo <= hstc_pkg::SEL_OFF;
          end
          if (fault_s[2*gi+1]) begin
            pair_q[gi].hi <= hstc_pkg::SEL_OFF;
          end
        end
      end
    end
  endgenerate

  // One timer feeds all four switches and the wake logic outside
  hstc_timer_b #(
    .TICK_CYC(TICK_CYC)
  ) u_hstc_timer_b (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(clr),
    .cfg_in(tmr_q),
    .level_out(tmr_level)
  );

  assign timer_b_out = tmr_level;

  // Per switch source mux, gated by supply fault
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sw
      hstc_pkg::hstc_sel_t sel;
      logic src;
      assign sel = (gi % 2 == 1) ? pair_q[gi/2].hi
        : pair_q[gi/2].lo;
      always_comb begin
        case (sel)
          hstc_pkg::SEL_OFF: src = 1'b0;
          hstc_pkg::SEL_ON: src = 1'b1;
          hstc_pkg::SEL_TMR_A: src = timer_a_in;
          hstc_pkg::SEL_TMR_B: src = tmr_level;
          hstc_pkg::SEL_PWM_A: src = pwm_source_a_in;
          hstc_pkg::SEL_PWM_B: src = pwm_source_b_in;
          default: src = 1'b0;
        endcase
      end
      always_ff @(posedge clk_sys_in) begin
        if (clr) begin
          switch_output_out[gi] <= 1'b0;
        end else begin
          switch_output_out[gi] <= src && !fault_now;
        end
      end
    end
  endgenerate

  a_rsv_read_zero: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (tmr_q & ~hstc_pkg::MASK_TMR_B) == 8'h00 &&
    (sd_q & ~hstc_pkg::MASK_SD) == 8'h00 &&
    (pair_q[0] & ~hstc_pkg::MASK_SEL) == 8'h00 &&
    (pair_q[1] & ~hstc_pkg::MASK_SEL) == 8'h00)
    else $error("reserved register bit is set");

  a_ov_shutdown: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    ov_s && !sd_q.ov_inhibit |=> switch_output_out == 4'h0)
    else $error("switch on during uninhibited overvoltage");

  a_uv_shutdown: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    uv_s && !sd_q.uv_inhibit |=> switch_output_out == 4'h0)
    else $error("switch on during uninhibited undervoltage");

  a_norec_off: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    rec_clr |=> pair_q[0] == 8'h00 && pair_q[1] == 8'h00)
    else $error("selects kept after fault without recovery");

  a_fault_clears_sel: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    fault_s[0] |=> pair_q[0].lo == hstc_pkg::SEL_OFF)
    else $error("switch one select kept after switch fault");

  a_restart_keep: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    rs_entry && !soft_rst_in |=>
      sd_q == ($past(sd_q) & hstc_pkg::RESTART_KEEP_SD))
    else $error("shutdown register wrong after restart entry");

  a_tmr_restart_clr: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    rs_entry || soft_rst_in |=> tmr_q == 8'h00 ##1 !timer_b_out)
    else $error("timer B not cleared by reset or restart");

  a_tmr_to_switch: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    pair_q[0].lo == hstc_pkg::SEL_TMR_B && !fault_now && !clr |=>
      switch_output_out[0] == $past(tmr_level))
    else $error("switch one does not follow timer B");

endmodule : hstc_top

/* testbench/hstc_mcu_model.sv */
// Microcontroller model: drives frames on the serial register port.
// Assumes the block syncs SCK and CSN with two flops on its own clock.
`timescale 1ns/1ns
module hstc_mcu_model (
  input wire logic clk_sys_in,
  input wire logic spi_sdo_in,
  output logic spi_csn_out,
  output logic spi_sck_out,
  output logic spi_sdi_out
);
  localparam int HALF = 5; // Clocks per SCK level, sync needs 3

  // Idle port: deselected, SCK low
  initial begin
    spi_csn_out = 1'b1;
    spi_sck_out = 1'b0;
    spi_sdi_out = 1'b0;
  end

  // Data line toggles while deselected so no stale bit survives
  always @(negedge clk_sys_in) begin
    if (spi_csn_out)
      spi_sdi_out <= ~spi_sdi_out;
  end

  // One 16-bit frame, LSB first, reads back the addressed byte
  task automatic frame(input logic [6:0] addr, input logic wr,
    input logic [7:0] wdata, output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {wdata, wr, addr};
    rdata = 8'h00;
    @(negedge clk_sys_in);
    spi_csn_out = 1'b0;
    @(negedge clk_sys_in); // Idle toggling has stopped by now
    for (int i = 0; i < 16; i++) begin
      spi_sdi_out = bits[i];
      repeat (HALF) @(negedge clk_sys_in);
      if (i >= 8)
        rdata[i-8] = spi_sdo_in;
      spi_sck_out = 1'b1;
      repeat (HALF) @(negedge clk_sys_in);
      spi_sck_out = 1'b0;
    end
    repeat (HALF) @(negedge clk_sys_in);
    spi_csn_out = 1'b1;
    repeat (8) @(negedge clk_sys_in); // Sync, commit, output update
  endtask : frame
endmodule : hstc_mcu_model

/* testbench/test_high_side_switch_timer_control.sv */
// Testbench for the switch select, shutdown and timer B block.
// Assumes a shortened timer step of TICK clocks per 0.1 ms.
`timescale 1ns/1ns
module test_high_side_switch_timer_control;
  localparam int TICK = 5;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic soft_rst_in = 1'b0;
  logic restart_mode_in = 1'b0;
  logic cyclic_sense_in = 1'b0;
  logic spi_csn_in, spi_sck_in, spi_sdi_in, spi_sdo_out;
  logic supply_ov_in = 1'b0;
  logic supply_uv_in = 1'b0;
  logic [3:0] switch_fault_in = 4'h0;
  logic timer_a_in = 1'b1;
  logic pwm_source_a_in = 1'b0;
  logic pwm_source_b_in = 1'b1;
  logic [3:0] switch_output_out;
  logic timer_b_out;
  int n_mismatch = 0;
  int checks_done = 0;
  // Config, window and expected high cycles (0.1 ms steps x TICK)
  logic [7:0] tcfg [9] = '{8'h10, 8'h20, 8'h30, 8'h41, 8'h52, 8'h60,
    8'h00, 8'h17, 8'h70};
  int twin [9] = '{1000, 500, 500, 1000, 2500, 100, 100, 1000, 100};
  int thi [9] = '{10, 15, 50, 500, 1000, 100, 0, 0, 0};
  logic [7:0] sel_exp = 8'h26; // Codes 1,2,5 high with these sources
  logic [7:0] sel_flip = 8'h34; // Codes 2,4,5 follow toggled sources

  always #10 clk_sys_in = ~clk_sys_in;

  hstc_top #(.TICK_CYC(TICK)) u_hstc_top (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .soft_rst_in(soft_rst_in),
    .restart_mode_in(restart_mode_in), .cyclic_sense_in(cyclic_sense_in),
    .spi_csn_in(spi_csn_in), .spi_sck_in(spi_sck_in),
    .spi_sdi_in(spi_sdi_in), .spi_sdo_out(spi_sdo_out),
    .supply_ov_in(supply_ov_in), .supply_uv_in(supply_uv_in),
    .switch_fault_in(switch_fault_in), .timer_a_in(timer_a_in),
    .pwm_source_a_in(pwm_source_a_in), .pwm_source_b_in(pwm_source_b_in),
    .switch_output_out(switch_output_out), .timer_b_out(timer_b_out));

  hstc_mcu_model u_hstc_mcu_model (.clk_sys_in(clk_sys_in),
    .spi_sdo_in(spi_sdo_out), .spi_csn_out(spi_csn_in),
    .spi_sck_out(spi_sck_in), .spi_sdi_out(spi_sdi_in));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
        exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_hstc_mcu_model.frame(a, 1'b1, d, r);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    u_hstc_mcu_model.frame(a, 1'b0, 8'h00, r);
    chk({8'h00, r}, {8'h00, e}, "register read");
  endtask : rd

  task automatic outs(input logic [3:0] e);
    chk({12'h000, switch_output_out}, {12'h000, e}, "switch outputs");
  endtask : outs

  // Count high cycles of timer B and switch one over a window
  task automatic cnt_hi(input int n, input int e);
    int ct, cs;
    ct = 0;
    cs = 0;
    repeat (n) begin
      @(negedge clk_sys_in);
      if (timer_b_out === 1'b1)
        ct++;
      if (switch_output_out[0] === 1'b1)
        cs++;
    end
    chk(16'(ct), 16'(e), "timer high cycles");
    chk(16'(cs), 16'(e), "switch follows timer");
  endtask : cnt_hi

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : wait_clk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // Watchdog at about three times the expected run of 16200 clocks
  initial begin
    repeat (50000) @(posedge clk_sys_in);
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  // Main sequence
  initial begin
    logic [15:0] v;
    wait_clk(12);
    sys_rst_in = 1'b0;
    wait_clk(3);
    // Reset values, masks and an unmapped address
    rd(hstc_pkg::ADDR_TMR_B, 8'h00);
    rd(hstc_pkg::ADDR_SD, 8'h00);
    wr(hstc_pkg::ADDR_SEL_B, 8'hFF);
    rd(hstc_pkg::ADDR_SEL_B, 8'h77);
    wr(hstc_pkg::ADDR_SD, 8'hFF);
    rd(hstc_pkg::ADDR_SD, 8'h70);
    wr(7'h11, 8'hFF);
    rd(7'h11, 8'h00);
    wr(hstc_pkg::ADDR_SEL_B, 8'h00);
    wr(hstc_pkg::ADDR_SD, 8'h00);
    $display("test registers done");
    // Timer B codes: switch assigned before the on-time is written
    wr(hstc_pkg::ADDR_SEL_A, 8'h03);
    for (int k = 0; k < 9; k++) begin
      wr(hstc_pkg::ADDR_TMR_B, tcfg[k]);
      cnt_hi(twin[k], thi[k]);
    end
    wr(hstc_pkg::ADDR_TMR_B, 8'h00);
    $display("test timer done");
    // Every select code on switch one, then each field position
    for (int k = 0; k < 8; k++) begin
      wr(hstc_pkg::ADDR_SEL_A, 8'(k));
      outs({3'b000, sel_exp[k]});
      {timer_a_in, pwm_source_a_in, pwm_source_b_in} = 3'b010;
      wait_clk(2);
      outs({3'b000, sel_exp[k] ^ sel_flip[k]});
      {timer_a_in, pwm_source_a_in, pwm_source_b_in} = 3'b101;
    end
    for (int p = 0; p < 4; p++) begin
      v = 16'h0001 << (4 * p);
      wr(hstc_pkg::ADDR_SEL_A, v[7:0]);
      wr(hstc_pkg::ADDR_SEL_B, v[15:8]);
      outs(4'(1 << p));
    end
    $display("test selects done");
    // Overvoltage without recovery clears selects
    wr(hstc_pkg::ADDR_SEL_A, 8'h11);
    supply_ov_in = 1'b1;
    wait_clk(6);
    outs(4'h0);
    supply_ov_in = 1'b0;
    wait_clk(6);
    outs(4'h0);
    rd(hstc_pkg::ADDR_SEL_A, 8'h00);
    // Undervoltage with recovery restores selects
    wr(hstc_pkg::ADDR_SD, 8'h10);
    wr(hstc_pkg::ADDR_SEL_A, 8'h11);
    supply_uv_in = 1'b1;
    wait_clk(6);
    outs(4'h0);
    supply_uv_in = 1'b0;
    wait_clk(6);
    outs(4'h3);
    // Inhibit bits keep switches active
    wr(hstc_pkg::ADDR_SD, 8'h60);
    supply_ov_in = 1'b1;
    supply_uv_in = 1'b1;
    wait_clk(6);
    outs(4'h3);
    supply_ov_in = 1'b0;
    supply_uv_in = 1'b0;
    $display("test supply done");
    // Switch fault clears its own select only
    wr(hstc_pkg::ADDR_SEL_B, 8'h11);
    switch_fault_in = 4'h8;
    wait_clk(6);
    switch_fault_in = 4'h0;
    wait_clk(3);
    outs(4'h7);
    rd(hstc_pkg::ADDR_SEL_B, 8'h01);
    $display("test fault done");
    // Restart entry keeps shutdown policy bits, clears the rest
    wr(hstc_pkg::ADDR_TMR_B, 8'h13);
    restart_mode_in = 1'b1;
    wait_clk(3);
    rd(hstc_pkg::ADDR_SD, 8'h60);
    rd(hstc_pkg::ADDR_TMR_B, 8'h00);
    rd(hstc_pkg::ADDR_SEL_A, 8'h00);
    // Hardware timer B register clear in restart with cyclic sensing
    cyclic_sense_in = 1'b1;
    wr(hstc_pkg::ADDR_SEL_A, 8'h03);
    wr(hstc_pkg::ADDR_TMR_B, 8'h13);
    switch_fault_in = 4'h1;
    wait_clk(6);
    switch_fault_in = 4'h0;
    rd(hstc_pkg::ADDR_TMR_B, 8'h00);
    restart_mode_in = 1'b0;
    cyclic_sense_in = 1'b0;
    // Soft reset clears timer B
    wr(hstc_pkg::ADDR_TMR_B, 8'h13);
    soft_rst_in = 1'b1;
    wait_clk(2);
    soft_rst_in = 1'b0;
    wait_clk(3);
    rd(hstc_pkg::ADDR_TMR_B, 8'h00);
    $display("test restart done");
    summarize();
  end
endmodule : test_high_side_switch_timer_control
